// ### fepc_ctrl.sv
// flash erase sequencing and protection control with axi4-lite registers
//
// How it works
// - erase setup bit prepares; erase pulse bit afterwards enters erase mode
// - erase needs no pre-programming of the block to zeros
// - leaving erase mode also clears the guard timer setting
// - verify read returns 16-bit data of the latched address
// - write pin low clears control one and both select registers, blocks all
// - reset, guard reset or standby clear control one and both select registers
// - fault flag aborts program or erase but keeps settings; verify stays possible
// - in fault state pulse bits are writable but modes are never entered
// - fault flag clears only on pin reset, guard reset or hardware standby
// - pin reset takes effect after being held 20 clock cycles
// - hardware protection makes every block unerasable; ram overlap drops only with the write pin low
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module fepc_ctrl (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins from outside the clock domain
  input  wire logic        flash_write_pin,
  input  wire logic        reset_pin_n,
  input  wire logic        hw_standby_pin_n,
  // system events on this clock
  input  wire logic        guard_timer_reset,
  input  wire logic        sw_standby,
  input  wire logic        cpu_fault_event,
  // cpu access to the flash array
  input  wire logic        cpu_flash_write,
  input  wire logic [23:0] cpu_flash_addr,
  input  wire logic [15:0] array_verify_data,
  // flash array control
  output logic             program_mode,
  output logic             erase_mode,
  output logic             program_check_mode,
  output logic             erase_check_mode,
  output logic [15:0]      erase_block_enable,
  output logic [23:0]      verify_addr,
  output logic [15:0]      verify_word,
  output logic             ram_overlap_enable,
  output logic             guard_timer_clear
);
  import fepc_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers and reset sources
  // ---------------------------------------------------------------
  logic [2:0] pin_level;
  logic       write_pin_high;
  logic       res_pin_low;
  logic       hw_standby;
  logic [4:0] res_count;
  logic       pin_reset;
  logic       clear_all;
  logic       clear_fault;

  fepc_pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h6)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_raw   ({hw_standby_pin_n, reset_pin_n, flash_write_pin}),
    .pin_level (pin_level)
  );

  assign write_pin_high = pin_level[0];
  assign res_pin_low    = ~pin_level[1];
  assign hw_standby     = ~pin_level[2];

  // count how long the reset pin has been held low
  always_ff @(posedge aclk) begin
    if (!aresetn || !res_pin_low) begin
      res_count <= 5'h0;
    end else if (res_count != FEPC_RESET_HOLD) begin
      res_count <= res_count + 5'h1;
    end
  end

  assign pin_reset   = (res_count == FEPC_RESET_HOLD);
  assign clear_fault = pin_reset | guard_timer_reset | hw_standby;
  assign clear_all   = clear_fault | sw_standby;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [6:0]  ctrl_one;
  logic [7:0]  ebs_low;
  logic [7:0]  ebs_high;
  logic        fault;
  logic [15:0] add_calc;
  logic        erase_setup_q;

  // axi write decode
  logic        wr_fire;
  logic        wr_lane0;
  logic        wr_ctrl_one;
  logic        wr_ctrl_two;
  logic        wr_ebs_low;
  logic        wr_ebs_high;
  logic        wr_add_calc;
  logic        wr_mapped;
  logic        sw_gate;
  logic [6:0]  next_ctrl_one;

  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign wr_lane0      = wr_fire & s_axi_wstrb[0];
  assign wr_ctrl_one   = wr_lane0 & (s_axi_awaddr == FEPC_ADDR_CTRL_ONE);
  assign wr_ctrl_two   = wr_lane0 & (s_axi_awaddr == FEPC_ADDR_CTRL_TWO);
  assign wr_ebs_low    = wr_lane0 & (s_axi_awaddr == FEPC_ADDR_EBS_LOW);
  assign wr_ebs_high   = wr_lane0 & (s_axi_awaddr == FEPC_ADDR_EBS_HIGH);
  assign wr_add_calc   = wr_fire & (s_axi_awaddr == FEPC_ADDR_ADD_CALC);
  assign wr_mapped     = (s_axi_awaddr == FEPC_ADDR_CTRL_ONE) | (s_axi_awaddr == FEPC_ADDR_CTRL_TWO)
                       | (s_axi_awaddr == FEPC_ADDR_EBS_LOW) | (s_axi_awaddr == FEPC_ADDR_EBS_HIGH)
                       | (s_axi_awaddr == FEPC_ADDR_STATUS) | (s_axi_awaddr == FEPC_ADDR_ADD_CALC)
                       | (s_axi_awaddr == FEPC_ADDR_VFY_WORD);

  // erase-side bits only take when write enable is set and the pin is high
  assign sw_gate = ctrl_one[FEPC_C1_SW_WRITE] & write_pin_high;

  // new control one value; gated bits keep their old value when locked
  always_comb begin
    next_ctrl_one = s_axi_wdata[6:0];
    if (!sw_gate) begin
      next_ctrl_one[FEPC_C1_ERASE_SET] = ctrl_one[FEPC_C1_ERASE_SET];
      next_ctrl_one[FEPC_C1_ERASE]     = ctrl_one[FEPC_C1_ERASE];
      next_ctrl_one[FEPC_C1_ERASE_CHK] = ctrl_one[FEPC_C1_ERASE_CHK];
    end
  end

  // control one: cleared by reset sources and by the write pin low
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_all || !write_pin_high) begin
      ctrl_one <= FEPC_CTRL_ONE_RST;
    end else if (wr_ctrl_one) begin
      ctrl_one <= next_ctrl_one;
    end
  end

  // erase block selects: same clearing as control one
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_all || !write_pin_high) begin
      ebs_low  <= FEPC_EBS_RST;
      ebs_high <= FEPC_EBS_RST;
    end else begin
      if (wr_ebs_low) begin
        ebs_low <= s_axi_wdata[7:0];
      end
      if (wr_ebs_high) begin
        ebs_high <= s_axi_wdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // modes and protection
  // ---------------------------------------------------------------
  logic        prog_active;
  logic        erase_active;
  logic        hw_prot;
  logic [15:0] ebs_all;
  logic        one_hot_sel;

  assign hw_prot      = ~write_pin_high | clear_all;
  assign prog_active  = ctrl_one[FEPC_C1_PROG] & ctrl_one[FEPC_C1_PROG_SETUP]
                      & ~program_check_mode & ~erase_check_mode;
  // setup then pulse enters erase; no pre-programming condition is checked
  assign erase_active = ctrl_one[FEPC_C1_ERASE] & ctrl_one[FEPC_C1_ERASE_SET];
  assign ebs_all      = {ebs_high, ebs_low};
  assign one_hot_sel  = (ebs_all != 16'h0000) & ((ebs_all & (ebs_all - 16'h0001)) == 16'h0000);

  // fault blocks entry even though the pulse bits read back set
  assign program_mode       = prog_active & ~fault & ~hw_prot;
  assign erase_mode         = erase_active & one_hot_sel & ~fault & ~hw_prot;
  assign erase_block_enable = (erase_mode) ? ebs_all : 16'h0000;
  assign ram_overlap_enable = write_pin_high;

  // verify stays possible in fault state, not under hardware protection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_check_mode <= 1'b0;
      erase_check_mode   <= 1'b0;
    end else begin
      program_check_mode <= ctrl_one[FEPC_C1_PROG_CHECK] & ~hw_prot;
      erase_check_mode   <= ctrl_one[FEPC_C1_ERASE_CHK] & ~hw_prot;
    end
  end

  // fault flag: set by a cpu fault during program or erase, cleared by pin reset, guard reset or hardware standby
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_fault) begin
      fault <= FEPC_FAULT_RST;
    end else if (cpu_fault_event && (program_mode || erase_mode)) begin
      fault <= 1'b1;
    end
  end

  // a falling erase setup bit means erase mode was left
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_setup_q     <= 1'b0;
      guard_timer_clear <= 1'b0;
    end else begin
      erase_setup_q     <= ctrl_one[FEPC_C1_ERASE_SET];
      guard_timer_clear <= erase_setup_q & ~ctrl_one[FEPC_C1_ERASE_SET];
    end
  end

  // ---------------------------------------------------------------
  // verify address latch and additional-programming helper
  // ---------------------------------------------------------------
  logic vfy_latch;

  assign vfy_latch = cpu_flash_write & (program_check_mode | erase_check_mode);

  // latch the dummy-write address, capture the array word at it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      verify_addr <= 24'h00_0000;
      verify_word <= 16'h0000;
    end else begin
      if (vfy_latch) begin
        verify_addr <= cpu_flash_addr;
      end
      verify_word <= array_verify_data;
    end
  end

  // software writes reprogram bits (low half) and verify bits (high half)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      add_calc <= 16'hFFFF;
    end else if (wr_add_calc) begin
      add_calc <= s_axi_wdata[15:0] | s_axi_wdata[31:16];
    end
  end

  // ---------------------------------------------------------------
  // axi response channels
  // ---------------------------------------------------------------
  logic [31:0] rd_value;
  logic        rd_mapped;
  logic [7:0]  status_val;

  assign status_val = {3'h0, hw_prot, erase_check_mode, program_check_mode, erase_mode, program_mode};
  assign s_axi_arready = ~s_axi_rvalid;

  // read mux
  always_comb begin
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      FEPC_ADDR_CTRL_ONE: rd_value = {24'h00_0000, write_pin_high, ctrl_one};
      FEPC_ADDR_CTRL_TWO: rd_value = {24'h00_0000, fault, 7'h00};
      FEPC_ADDR_EBS_LOW:  rd_value = {24'h00_0000, ebs_low};
      FEPC_ADDR_EBS_HIGH: rd_value = {24'h00_0000, ebs_high};
      FEPC_ADDR_STATUS:   rd_value = {24'h00_0000, status_val};
      FEPC_ADDR_ADD_CALC: rd_value = {16'h0000, add_calc};
      FEPC_ADDR_VFY_WORD: rd_value = {16'h0000, verify_word};
      default: begin
        rd_value  = 32'h0000_0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= FEPC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? FEPC_RESP_OKAY : FEPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= FEPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_mapped ? FEPC_RESP_OKAY : FEPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### fepc_pkg.sv
// constants for the flash erase and protection control block
package fepc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] FEPC_ADDR_CTRL_ONE  = 8'h00;
  localparam logic [7:0] FEPC_ADDR_CTRL_TWO  = 8'h04;
  localparam logic [7:0] FEPC_ADDR_EBS_LOW   = 8'h08;
  localparam logic [7:0] FEPC_ADDR_EBS_HIGH  = 8'h0C;
  localparam logic [7:0] FEPC_ADDR_STATUS    = 8'h10;
  localparam logic [7:0] FEPC_ADDR_ADD_CALC  = 8'h14;
  localparam logic [7:0] FEPC_ADDR_VFY_WORD  = 8'h18;

  // ---------------------------------------------------------------
  // flash_control_one field positions
  // ---------------------------------------------------------------
  localparam int FEPC_C1_PROG       = 0;
  localparam int FEPC_C1_ERASE      = 1;
  localparam int FEPC_C1_PROG_CHECK = 2;
  localparam int FEPC_C1_ERASE_CHK  = 3;
  localparam int FEPC_C1_PROG_SETUP = 4;
  localparam int FEPC_C1_ERASE_SET  = 5;
  localparam int FEPC_C1_SW_WRITE   = 6;
  localparam int FEPC_C1_PIN_LEVEL  = 7;

  // flash_control_two field position
  localparam int FEPC_C2_FAULT      = 7;

  // status register field positions
  localparam int FEPC_ST_PROG_MODE  = 0;
  localparam int FEPC_ST_ERASE_MODE = 1;
  localparam int FEPC_ST_PVFY_MODE  = 2;
  localparam int FEPC_ST_EVFY_MODE  = 3;
  localparam int FEPC_ST_HW_PROT    = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] FEPC_CTRL_ONE_RST = 7'h00;
  localparam logic [7:0] FEPC_EBS_RST      = 8'h00;
  localparam logic       FEPC_FAULT_RST    = 1'b0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         FEPC_RESET_HOLD_CYCLES = 20;
  localparam logic [4:0] FEPC_RESET_HOLD        = 5'(FEPC_RESET_HOLD_CYCLES);

  // axi responses
  localparam logic [1:0] FEPC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FEPC_RESP_SLVERR = 2'h2;

endpackage

// ### fepc_pin_sync.sv
// three-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module fepc_pin_sync #(
  parameter int         WIDTH     = 3,
  parameter logic [2:0] RESET_VAL = 3'h0
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_raw,
  output logic      [WIDTH-1:0] pin_level
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // s1 feeds only s2; a change counts when s2 and s3 agree
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1           <= RESET_VAL[i];
          s2           <= RESET_VAL[i];
          s3           <= RESET_VAL[i];
          pin_level[i] <= RESET_VAL[i];
        end else begin
          s1 <= pin_raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_level[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule

// ### fepc_ctrl_assertions.sv
// concurrent checks on the ports of the flash erase and protection block
`timescale 1ns/10ps
module fepc_ctrl_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // flash side
  input wire logic        cpu_fault_event,
  input wire logic        cpu_flash_write,
  input wire logic [23:0] cpu_flash_addr,
  input wire logic        erase_mode,
  input wire logic        erase_check_mode,
  input wire logic [15:0] erase_block_enable,
  input wire logic [23:0] verify_addr,
  input wire logic        ram_overlap_enable,
  input wire logic        guard_timer_clear
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // -------------------------------------------------
  // erase path
  // -------------------------------------------------
  blocks_need_erase_a: assert property (erase_block_enable != 16'h0000 |-> erase_mode)
    else $error("block enable outside erase mode");
  one_block_a: assert property (erase_mode |-> $onehot(erase_block_enable))
    else $error("erase mode without a single block");
  erase_needs_pin_a: assert property (erase_mode |-> ram_overlap_enable)
    else $error("erase mode while write pin low");
  fault_stops_erase_a: assert property (erase_mode && cpu_fault_event |=> !erase_mode [*3])
    else $error("erase continued after fault");
  guard_clear_idle_a: assert property (guard_timer_clear |-> !erase_mode)
    else $error("guard clear while erasing");
  verify_latch_a: assert property (erase_check_mode && cpu_flash_write |=>
      verify_addr == $past(cpu_flash_addr))
    else $error("dummy write address not latched");

  // -------------------------------------------------
  // register bus
  // -------------------------------------------------
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  take_both_a: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
    else $error("write taken without both channels");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  // main scenarios
  erase_c: cover property (erase_mode);
  clear_c: cover property (guard_timer_clear);
  verify_c: cover property (erase_check_mode && cpu_flash_write);
endmodule

// ### tb_top.sv
// self-checking bench for the flash erase and protection block
`timescale 1ns/10ps
module tb_top;
  import fepc_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0]  rs, bs;
  logic        wpin = 1, rpin_n = 1, hsb_n = 1, gtr = 0, sstb = 0, fev = 0, fwr = 0;
  logic [23:0] faddr = 0, vaddr;
  logic        pmode, emode, pcm, ecm, ram_en, gclr;
  logic [15:0] blk, vword, avd = 16'hA5C3;
  int          bad_count = 0, checked = 0, gclr_seen = 0;
  // indices of the side-band inputs that pulse() can flip
  localparam int FEV = 0, GTR = 1, SSTB = 2, WPIN = 3, RPIN = 4, HSB = 5;

  always #20 aclk = ~aclk;

  fepc_ctrl dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_write_pin(wpin), .reset_pin_n(rpin_n), .hw_standby_pin_n(hsb_n),
    .guard_timer_reset(gtr), .sw_standby(sstb), .cpu_fault_event(fev),
    .cpu_flash_write(fwr), .cpu_flash_addr(faddr), .array_verify_data(avd),
    .program_mode(pmode), .erase_mode(emode), .program_check_mode(pcm), .erase_check_mode(ecm),
    .erase_block_enable(blk), .verify_addr(vaddr), .verify_word(vword),
    .ram_overlap_enable(ram_en), .guard_timer_clear(gclr)
  );

  // counts guard clear pulses
  always @(posedge aclk) if (gclr === 1'b1) gclr_seen++;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // bus write, waits for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 0; wvalid <= 0;
    while (bvalid !== 1'b1) @(posedge aclk);
    bs = bresp;
    bready <= 0;
  endtask

  // bus read, returns data and response
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata; r = rresp; rready <= 0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    rdw(a, rd, rs);
    check(name, rd, exp);
  endtask

  // flips one side-band input, picked by index
  task automatic flip(input int k);
    case (k)
      FEV:     fev <= ~fev;
      GTR:     gtr <= ~gtr;
      SSTB:    sstb <= ~sstb;
      WPIN:    wpin <= ~wpin;
      RPIN:    rpin_n <= ~rpin_n;
      default: hsb_n <= ~hsb_n;
    endcase
  endtask

  task automatic pulse(input int k, input int n);
    @(posedge aclk); flip(k);
    repeat (n) @(posedge aclk);
    flip(k);
    repeat (6) @(posedge aclk);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    // the write pin level needs four edges through the synchroniser
    repeat (6) @(posedge aclk);
    rchk("ctrl1 reset", FEPC_ADDR_CTRL_ONE, 32'h0000_0080);
    check("ram overlap", ram_en, 1'b1);
    rdw(8'h1C, rd, rs);
    check("unmapped resp", rs, FEPC_RESP_SLVERR);
    wr(8'h1C, 32'h0000_0000);
    check("unmapped wresp", bs, FEPC_RESP_SLVERR);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0020);
    check("write resp", bs, FEPC_RESP_OKAY);
    rchk("setup no swe", FEPC_ADDR_CTRL_ONE, 32'h0000_0080);
    wr(FEPC_ADDR_ADD_CALC, 32'h0F0F_00FF);
    rdw(FEPC_ADDR_ADD_CALC, rd, rs);
    check("add calc", rd[15:0], 16'h0FFF);
    // single block erase: write enable first, then one select bit
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0040);
    wr(FEPC_ADDR_EBS_LOW, 32'h0000_0004);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0060);
    check("setup only", emode, 1'b0);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0062);
    check("erase mode", emode, 1'b1);
    check("block enable", blk, 16'h0004);
    rchk("status erase", FEPC_ADDR_STATUS, 32'h0000_0002);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0060);
    check("erase off", emode, 1'b0);
    check("no clear yet", gclr_seen, 0);
    repeat (2) @(posedge aclk);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0040);
    repeat (3) @(posedge aclk);
    check("guard clear", gclr_seen, 1);
    // erase verify with dummy write
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0048);
    repeat (2) @(posedge aclk);
    check("verify mode", ecm, 1'b1);
    faddr <= 24'h00_1234; fwr <= 1;
    @(posedge aclk); fwr <= 0;
    repeat (2) @(posedge aclk);
    check("verify addr", vaddr, 24'h00_1234);
    rchk("verify word", FEPC_ADDR_VFY_WORD, 32'h0000_A5C3);
    // word not erased: erase again, a fault hits it
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0060);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0062);
    pulse(FEV, 1);
    check("fault abort", emode, 1'b0);
    rchk("fault flag", FEPC_ADDR_CTRL_TWO, 32'h0000_0080);
    rchk("ctrl1 kept", FEPC_ADDR_CTRL_ONE, 32'h0000_00E2);
    wr(FEPC_ADDR_CTRL_TWO, 32'h0000_0000);
    rchk("fault stays", FEPC_ADDR_CTRL_TWO, 32'h0000_0080);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_006A);
    repeat (2) @(posedge aclk);
    check("no re-entry", emode, 1'b0);
    check("verify in fault", ecm, 1'b1);
    avd <= 16'hFFFF;
    rchk("erased word", FEPC_ADDR_VFY_WORD, 32'h0000_FFFF);
    pulse(GTR, 1);
    rchk("fault cleared", FEPC_ADDR_CTRL_TWO, 32'h0000_0000);
    rchk("ctrl1 guard rst", FEPC_ADDR_CTRL_ONE, 32'h0000_0080);
    rchk("sel guard rst", FEPC_ADDR_EBS_LOW, 32'h0000_0000);
    // lane 0 strobe low leaves the byte register alone
    wstrb <= 4'hE;
    wr(FEPC_ADDR_EBS_LOW, 32'h0000_0008);
    wstrb <= 4'hF;
    rchk("strobe ignored", FEPC_ADDR_EBS_LOW, 32'h0000_0000);
    // software standby
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0040);
    wr(FEPC_ADDR_EBS_HIGH, 32'h0000_0001);
    pulse(SSTB, 1);
    rchk("sel standby", FEPC_ADDR_EBS_HIGH, 32'h0000_0000);
    rchk("ctrl1 standby", FEPC_ADDR_CTRL_ONE, 32'h0000_0080);
    // write pin protection
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0040);
    wr(FEPC_ADDR_EBS_LOW, 32'h0000_0002);
    pulse(WPIN, 8);
    wpin <= 0;
    repeat (6) @(posedge aclk);
    check("overlap dropped", ram_en, 1'b0);
    rchk("ctrl1 pin low", FEPC_ADDR_CTRL_ONE, 32'h0000_0000);
    rchk("sel pin low", FEPC_ADDR_EBS_LOW, 32'h0000_0000);
    rchk("hw prot", FEPC_ADDR_STATUS, 32'h0000_0010);
    wpin <= 1;
    repeat (6) @(posedge aclk);
    // reset pin needs a long enough hold
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0040);
    pulse(RPIN, 10);
    rchk("short reset", FEPC_ADDR_CTRL_ONE, 32'h0000_00C0);
    pulse(RPIN, 30);
    rchk("long reset", FEPC_ADDR_CTRL_ONE, 32'h0000_0080);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0040);
    pulse(HSB, 6);
    rchk("hw standby", FEPC_ADDR_CTRL_ONE, 32'h0000_0080);
    // program path with the pin high, then verify left and write enable cleared
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0011);
    check("program mode", pmode, 1'b1);
    rchk("status prog", FEPC_ADDR_STATUS, 32'h0000_0001);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0044);
    repeat (2) @(posedge aclk);
    check("prog verify", pcm, 1'b1);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0040);
    repeat (2) @(posedge aclk);
    check("verify left", pcm, 1'b0);
    wr(FEPC_ADDR_CTRL_ONE, 32'h0000_0000);
    rchk("swe cleared", FEPC_ADDR_CTRL_ONE, 32'h0000_0080);
    tally_and_finish();
  end
endmodule

bind fepc_ctrl fepc_ctrl_chk chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cpu_fault_event(cpu_fault_event), .cpu_flash_write(cpu_flash_write), .cpu_flash_addr(cpu_flash_addr),
  .erase_mode(erase_mode), .erase_check_mode(erase_check_mode), .erase_block_enable(erase_block_enable),
  .verify_addr(verify_addr), .ram_overlap_enable(ram_overlap_enable), .guard_timer_clear(guard_timer_clear)
);
